// *** hdl/lfps_defines.vh ***
// Constants of the low-frequency pulse shaper and its register crossing.
// Assumes inclusion by bare name from every design file of this block.
`ifndef LFPS_DEFINES_VH
`define LFPS_DEFINES_VH

// ==========================================================================
// Register byte offsets on the APB side
`define LFPS_ADDR_W            12
`define LFPS_OFS_PULSE_CTRL    12'h03c
`define LFPS_OFS_UPDATE_HOLD   12'h040
`define LFPS_OFS_SYNC_BUSY     12'h044

// ==========================================================================
// Field layout of pulse_shaping_control
`define LFPS_PC_W              6
`define LFPS_PC_FILT_BIT       5
`define LFPS_PC_EN_BIT         4
`define LFPS_PC_WIDTH_MSB      3
`define LFPS_PC_WIDTH_LSB      0
`define LFPS_PC_RESET          6'h00

// ==========================================================================
// Field layout of update_hold_control and sync_busy_status
`define LFPS_HOLD_BIT          0
`define LFPS_HOLD_RESET        1'h0
`define LFPS_BUSY_W            8
`define LFPS_BUSY_PULSE_BIT    7
`define LFPS_BUSY_RESET        8'h00
`define LFPS_EXT_REGS          7

// ==========================================================================
// Timing: bus clock and the 32.768 kHz low-frequency rate
`define LFPS_CLK_HZ            100000000
`define LFPS_LF_HZ             32768
`define LFPS_LF_DIV            (`LFPS_CLK_HZ / `LFPS_LF_HZ)

// ==========================================================================
// Pin idle level and stretched-bit length in low-frequency cycles
`define LFPS_LINE_IDLE         1'h1
`define LFPS_BIT_TICKS         3

`endif

// *** hdl/lfps_pin_sync.v ***
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to clock; output changes only when the
// second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
`include "lfps_defines.vh"

module lfps_pin_sync #(
    parameter RESET_LEVEL = `LFPS_LINE_IDLE
) (
    // Clock and reset
    input  wire clock,
    input  wire reset_n,
    // Pin and clean level
    input  wire pinAsync,
    output reg  pinClean_reg
);

    reg stage1_reg;
    reg stage2_reg;
    reg stage3_reg;

    // ======================================================================
    // Chain; first stage feeds only the second to limit metastability
    always @(posedge clock) begin
        if (!reset_n) begin
            stage1_reg   <= RESET_LEVEL;
            stage2_reg   <= RESET_LEVEL;
            stage3_reg   <= RESET_LEVEL;
            pinClean_reg <= RESET_LEVEL;
        end else begin
            stage1_reg <= pinAsync;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                pinClean_reg <= stage3_reg; // Agreed level only
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/lfps_sync_slot.v ***
// One register crossing slot: tracks a pending bus write until it is
// applied on a low-frequency tick. Assumes lfTick is one clock wide.
`timescale 1ns/10ps
`default_nettype none
`include "lfps_defines.vh"

module lfps_sync_slot (
    // Clock and reset
    input  wire clock,
    input  wire reset_n,
    // Bus-side write and global hold
    input  wire writeStrobe,
    input  wire holdUpdates,
    input  wire lfTick,
    // Status and low-frequency apply pulse
    output reg  busy_reg,
    output reg  apply_reg
);

    wire applyNow;
    wire busy_next;

    // Apply only on a tick while updates are not held back
    assign applyNow  = busy_reg & lfTick & ~holdUpdates;
    // A write in the apply cycle keeps the slot busy: set beats clear
    assign busy_next = (busy_reg & ~applyNow) | writeStrobe;

    // ======================================================================
    // Pending flag and apply pulse
    always @(posedge clock) begin
        if (!reset_n) begin
            busy_reg  <= 1'h0;
            apply_reg <= 1'h0;
        end else begin
            busy_reg  <= busy_next;
            apply_reg <= applyNow;
        end
    end

endmodule
`default_nettype wire

// *** hdl/lfps_top.v ***
// Pulse shaper and low-frequency register crossing of a low-energy serial
// port, with an APB slave for its control registers.
// Assumes txSerial and baudTick come from the port core on the same clock
// and rxPin comes straight from a pad.
// The low-frequency clock is modelled as a one-clock tick on clock.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lfps_defines.vh"

module lfps_top #(
    parameter LF_DIV    = `LFPS_LF_DIV,
    parameter BIT_TICKS = `LFPS_BIT_TICKS
) (
    // Clock and reset
    input  wire                        clock,
    input  wire                        reset_n,
    // APB slave
    input  wire                        psel,
    input  wire                        penable,
    input  wire                        pwrite,
    input  wire [`LFPS_ADDR_W-1:0]     paddr,
    input  wire [31:0]                 pwdata,
    output reg  [31:0]                 prdata,
    output reg                         pready,
    output reg                         pslverr,
    // Crossing slots of the other port registers
    input  wire [`LFPS_EXT_REGS-1:0]   extWriteStrobe,
    output wire [`LFPS_EXT_REGS-1:0]   extApply,
    // Serial core side
    input  wire                        txSerial,
    input  wire                        baudTick,
    output reg                         rxToCore,
    // Pins
    output reg                         txPin,
    input  wire                        rxPin
);

    // ======================================================================
    // Declarations
    // Flip-flops end in _reg, except the ports prdata, pready, pslverr, txPin and rxToCore.
    reg  [`LFPS_PC_W-1:0]      pulseShadow_reg;
    reg  [`LFPS_PC_W-1:0]      pulseActive_reg;
    reg                        holdUpdates_reg;
    reg  [11:0]                lfCount_reg;
    reg                        lfTick_reg;
    reg  [3:0]                 txPulseCnt_reg;
    reg                        rxPrevLow_reg;
    reg  [3:0]                 rxStretch_reg;
    reg                        rxDetect;
    reg  [31:0]                readData;
    reg                        addrHit;
    wire                       apbAccess;
    wire                       apbDone;
    wire                       apbWrite;
    wire                       pulseWrite;
    wire                       pulseApply;
    wire                       pulseBusy;
    wire [`LFPS_EXT_REGS-1:0]  extBusy;
    wire [`LFPS_BUSY_W-1:0]    busyVector;
    wire                       rxClean;
    wire                       shapeEnable;
    wire                       filterEnable;
    wire [3:0]                 pulseWidth;
    wire [3:0]                 pulseLoad;

    // Parameters are integers; cut them to counter width on purpose.
    // LF_DIV above 4096 or BIT_TICKS above 15 would wrap.
    localparam integer LF_LAST_INT   = LF_DIV - 1;
    localparam integer BIT_COUNT_INT = BIT_TICKS;
    localparam [11:0]  LF_LAST       = LF_LAST_INT[11:0];
    localparam [3:0]   BIT_COUNT     = BIT_COUNT_INT[3:0];

    // ======================================================================
    // APB handshake
    // One wait state: pready rises the cycle after the access phase opens,
    // so read data and the error answer can both come from flip-flops.
    // A new setup right after pready is fine: pready drops for a cycle,
    // so the access of the next transfer is never answered early.
    assign apbAccess = psel & penable;
    assign apbDone   = apbAccess & pready;
    assign apbWrite  = apbDone & pwrite & ~pslverr;

    // Address decode and read mux of the register map
    // The address is compared in full, so aliases answer with pslverr.
    // Unused read bits stay zero, so reserved fields always read as 0.
    always @* begin
        readData = 32'h0000_0000;
        addrHit  = 1'h1;
        case (paddr)
            `LFPS_OFS_PULSE_CTRL: begin
                readData[`LFPS_PC_W-1:0] = pulseShadow_reg;
            end
            `LFPS_OFS_UPDATE_HOLD: begin
                readData[`LFPS_HOLD_BIT] = holdUpdates_reg;
            end
            `LFPS_OFS_SYNC_BUSY: begin
                readData[`LFPS_BUSY_W-1:0] = busyVector;
            end
            default: begin
                addrHit = 1'h0;
            end
        endcase
    end

    // Bus answer registers; unmapped addresses answer with pslverr
    // A write answers with zero data rather than a stale read value;
    // between transfers prdata simply holds its last answer.
    // pready is cleared after one cycle high, never held.
    always @(posedge clock) begin
        if (!reset_n) begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h0000_0000;
        end else if (apbAccess && !pready) begin
            pready  <= 1'h1;
            pslverr <= ~addrHit;
            prdata  <= (pwrite || !addrHit) ? 32'h0000_0000 : readData;
        end else begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
        end
    end

    // ======================================================================
    // Bus-side registers
    // Only an accepted, error-free access changes a register; the write
    // lands on the edge at which the master sees pready high.
    assign pulseWrite = apbWrite && (paddr == `LFPS_OFS_PULSE_CTRL);

    // software zeroes
    // Reserved bits are not stored, so stray ones are simply dropped.
    // hold bit write
    // The hold bit itself acts at once; it is not a crossed register.
    always @(posedge clock) begin
        if (!reset_n) begin
            pulseShadow_reg <= `LFPS_PC_RESET;
            holdUpdates_reg <= `LFPS_HOLD_RESET;
        end else begin
            if (pulseWrite) begin
                pulseShadow_reg <= pwdata[`LFPS_PC_W-1:0];
            end
            if (apbWrite && (paddr == `LFPS_OFS_UPDATE_HOLD)) begin
                holdUpdates_reg <= pwdata[`LFPS_HOLD_BIT];
            end
        end
    end

    // ======================================================================
    // Low-frequency tick
    // The 32.768 kHz domain is modelled as a tick on the bus clock; the
    // divider rounds down, so the rate is a touch fast.
    // lfTick_reg is one clock wide and stands for the low-frequency
    // clock edge, so no consumer needs a crossing of its own.
    // Its phase is free-running and unrelated to bus writes.
    always @(posedge clock) begin
        if (!reset_n) begin
            lfCount_reg <= 12'h000;
            lfTick_reg  <= 1'h0;
        end else if (lfCount_reg == LF_LAST) begin
            lfCount_reg <= 12'h000;
            lfTick_reg  <= 1'h1;
        end else begin
            lfCount_reg <= lfCount_reg + 12'h001;
            lfTick_reg  <= 1'h0;
        end
    end

    // ======================================================================
    // Crossing slots
    // Each slot holds a busy flag from the bus write to the next tick
    // with updates released; the pulse slot also gates the active copy.
    // pulse control crossing
    lfps_sync_slot pulseSlot (
        .clock       (clock),
        .reset_n     (reset_n),
        .writeStrobe (pulseWrite),
        .holdUpdates (holdUpdates_reg),
        .lfTick      (lfTick_reg),
        .busy_reg    (pulseBusy),
        .apply_reg   (pulseApply)
    );

    // shared hold
    // All slots see one hold and one tick, so held writes land together.
    // The other port registers live outside this block; only their
    // pending flags and apply pulses are kept here.
    genvar slot;
    generate
        for (slot = 0; slot < `LFPS_EXT_REGS; slot = slot + 1) begin : gSlot
            lfps_sync_slot extSlot (
                .clock       (clock),
                .reset_n     (reset_n),
                .writeStrobe (extWriteStrobe[slot]),
                .holdUpdates (holdUpdates_reg),
                .lfTick      (lfTick_reg),
                .busy_reg    (extBusy[slot]),
                .apply_reg   (extApply[slot])
            );
        end
    endgenerate

    // Pulse control takes the top busy bit and the other slots the rest,
    // so software polls one word for every crossing in flight.
    // busy flag map
    assign busyVector = {pulseBusy, extBusy};

    // old settings kept
    // Active copy changes only on an apply pulse, never after the first held cycle.
    // The shapers thus act one clock after the apply pulse and never
    // see a value that software is still changing.
    always @(posedge clock) begin
        if (!reset_n) begin
            pulseActive_reg <= `LFPS_PC_RESET;
        end else if (pulseApply) begin
            pulseActive_reg <= pulseShadow_reg;
        end
    end

    // Field views of the active copy; only these feed the shapers
    assign shapeEnable  = pulseActive_reg[`LFPS_PC_EN_BIT];
    assign filterEnable = pulseActive_reg[`LFPS_PC_FILT_BIT];
    assign pulseWidth   = pulseActive_reg[`LFPS_PC_WIDTH_MSB:
                                          `LFPS_PC_WIDTH_LSB];
    // A zero width would emit nothing; it is given one cycle instead
    assign pulseLoad    = (pulseWidth == 4'h0) ? 4'h1 : pulseWidth;

    // ======================================================================
    // Transmit pulse generator
    // output via generator
    // pulse width count
    // A low bit seen at a bit boundary starts a low pulse counted in
    // low-frequency cycles; between pulses the line idles high.
    // The end is taken on a tick, so a pulse may come out up to one
    // low-frequency cycle shorter than its width.
    // A new low bit during a pulse restarts it at full width.
    always @(posedge clock) begin
        if (!reset_n) begin
            txPulseCnt_reg <= 4'h0;
            txPin          <= `LFPS_LINE_IDLE;
        end else if (!shapeEnable) begin
            txPulseCnt_reg <= 4'h0;
            txPin          <= txSerial;
        end else if (baudTick && !txSerial) begin
            txPulseCnt_reg <= pulseLoad;
            txPin          <= ~`LFPS_LINE_IDLE;
        end else if (txPulseCnt_reg != 4'h0) begin
            if (lfTick_reg) begin
                txPulseCnt_reg <= txPulseCnt_reg - 4'h1;
            end
            txPin <= ~`LFPS_LINE_IDLE;
            if (lfTick_reg && txPulseCnt_reg == 4'h1) begin
                txPin <= `LFPS_LINE_IDLE;
            end
        end else begin
            txPin <= `LFPS_LINE_IDLE;
        end
    end

    // ======================================================================
    // Receive pin synchroniser
    // The pad is asynchronous; three stages plus agreement cost about
    // four clocks, far below one low-frequency cycle.
    // The stages reset to the idle level, so no false edge follows.
    lfps_pin_sync rxSync (
        .clock        (clock),
        .reset_n      (reset_n),
        .pinAsync     (rxPin),
        .pinClean_reg (rxClean)
    );

    // ======================================================================
    // Receive pulse detection
    // unfiltered detection
    // one-cycle filter
    // The line is sampled once per low-frequency cycle; with the filter
    // on, two low samples in a row are needed, which costs one cycle of
    // latency and the shortest pulses.
    // A glitch of one low-frequency cycle yields one low sample at most.
    always @* begin
        rxDetect = 1'h0;
        if (lfTick_reg && rxClean == ~`LFPS_LINE_IDLE) begin
            rxDetect = filterEnable ? rxPrevLow_reg : 1'h1;
        end
    end

    // Previous low-frequency sample, for the filter
    // Updated on every tick, even with shaping off, so a stale low is
    // never left over when the extender is switched on.
    always @(posedge clock) begin
        if (!reset_n) begin
            rxPrevLow_reg <= 1'h0;
        end else if (lfTick_reg) begin
            rxPrevLow_reg <= (rxClean == ~`LFPS_LINE_IDLE);
        end
    end

    // ======================================================================
    // Receive pulse extender
    // input via extender
    // stretch to bit
    // Each detection holds the line low for a full bit of low-frequency
    // cycles; a new detection restarts the count.
    // With shaping off the core sees the synchronised pin directly and
    // the count is cleared, so no old stretch resumes later.
    always @(posedge clock) begin
        if (!reset_n) begin
            rxStretch_reg <= 4'h0;
            rxToCore      <= `LFPS_LINE_IDLE;
        end else if (!shapeEnable) begin
            rxStretch_reg <= 4'h0;
            rxToCore      <= rxClean;
        end else if (rxDetect) begin
            rxStretch_reg <= BIT_COUNT;
            rxToCore      <= ~`LFPS_LINE_IDLE;
        end else if (rxStretch_reg != 4'h0) begin
            if (lfTick_reg) begin
                rxStretch_reg <= rxStretch_reg - 4'h1;
            end
            rxToCore <= ~`LFPS_LINE_IDLE;
            if (lfTick_reg && rxStretch_reg == 4'h1) begin
                rxToCore <= `LFPS_LINE_IDLE;
            end
        end else begin
            rxToCore <= `LFPS_LINE_IDLE;
        end
    end

endmodule
`default_nettype wire

// *** verification/lfps_top_properties.sv ***
// Port checker of lfps_top: APB answers, crossing and pin idle levels.
// Assumes it is bound into lfps_top and shares its LF_DIV.
`timescale 1ns/10ps
`default_nettype none
`include "lfps_defines.vh"
module lfps_top_properties #(
    parameter int LF_DIV = 3051
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Crossing and pins
    input wire logic [6:0]  extWriteStrobe,
    input wire logic [6:0]  extApply,
    input wire logic        txPin,
    input wire logic        rxToCore
);
    // ======
    // Helper state: hold bit as written, wait of a pending slot 0 write
    logic holdSeen;
    logic extPend;
    int   pendCnt;
    wire  mapped = paddr == `LFPS_OFS_PULSE_CTRL
                || paddr == `LFPS_OFS_UPDATE_HOLD
                || paddr == `LFPS_OFS_SYNC_BUSY;
    // Counter restarts while held, so only unheld waiting is bounded
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            holdSeen <= 1'b0;
            extPend  <= 1'b0;
            pendCnt  <= 0;
        end else begin
            if (psel && penable && pready && pwrite
                && paddr == `LFPS_OFS_UPDATE_HOLD)
                holdSeen <= pwdata[0];
            if (extWriteStrobe[0])
                extPend <= 1'b1;
            else if (extApply[0])
                extPend <= 1'b0;
            pendCnt <= (extPend && !holdSeen && !extApply[0])
                       ? pendCnt + 1 : 0;
        end
    end

    // ======
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_bus_answer: assert property (s_access |=> s_answer)
        else $error("APB answer not after one wait state");
    a_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("error flag does not match address decode");
    a_err_zero: assert property (pslverr |-> pready && prdata == 0)
        else $error("refused access with data or without ready");
    a_busy_reserved: assert property (
        pready && !pwrite && paddr == `LFPS_OFS_SYNC_BUSY
        |-> prdata[31:8] == 0)
        else $error("busy status reserved bits not zero");
    a_hold_blocks: assert property (
        holdSeen && $past(holdSeen) |-> extApply == 7'h00)
        else $error("apply while updates are held");
    a_apply_bound: assert property (pendCnt <= LF_DIV + 2)
        else $error("pending write not applied in one tick");
    a_apply_pulse: assert property (extApply[0] |=> !extApply[0])
        else $error("apply pulse longer than one cycle");
    a_reset_idle: assert property (disable iff (1'b0)
        !reset_n |=> txPin && rxToCore && !pready && extApply == 0)
        else $error("outputs not idle after reset");
endmodule
bind lfps_top lfps_top_properties #(.LF_DIV(LF_DIV)) lfps_top_properties_inst (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extWriteStrobe(extWriteStrobe),
    .extApply(extApply), .txPin(txPin), .rxToCore(rxToCore));
`default_nettype wire

// *** verification/tb_lfps_top.sv ***
// Self-checking bench of lfps_top over APB and the serial pins.
// Assumes a short low-frequency divider and the default stretch length.
`timescale 1ns/10ps
`default_nettype none
`include "lfps_defines.vh"
module tb_lfps_top;
    localparam int    DIV = 8;
    localparam [11:0] PC  = `LFPS_OFS_PULSE_CTRL;
    localparam [11:0] HD  = `LFPS_OFS_UPDATE_HOLD;
    localparam [11:0] SB  = `LFPS_OFS_SYNC_BUSY;
    logic        clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, rxToCore, txPin;
    logic [6:0]  extWriteStrobe = 0;
    wire  [6:0]  extApply;
    logic        txSerial = 1, baudTick = 0, rxPin = 1, err;
    int          bad_count = 0, num_checks = 0, applyCnt = 0, base, n;
    int          widths[$];
    // Model of the control register as software wrote it
    int          mCtrl;

    initial forever #5 clock = ~clock;
    lfps_top #(.LF_DIV(DIV)) lfps_top_inst (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extWriteStrobe(extWriteStrobe),
        .extApply(extApply), .txSerial(txSerial), .baudTick(baudTick),
        .rxToCore(rxToCore), .txPin(txPin), .rxPin(rxPin));
    // Apply pulses seen, counted from the sampled values
    always @(posedge clock) applyCnt <= applyCnt + $countones(extApply);

    // ======
    // Shared tasks
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Request held until pready is sampled high
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (!pready);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        // One idle edge, so a following call never reassigns psel at once
        @(posedge clock);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1, a, d);
        if (a == PC)
            mCtrl = d[5:0];
    endtask
    task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
        apb(0, a, 0);
        check(what, exp, rd);
    endtask
    // A read takes four cycles, so a tick's wait fits a few polls
    task automatic waitIdle();
        int k;
        k = 0;
        do begin
            apb(0, SB, 0);
            k++;
        end while (rd[7:0] !== 0 && k < 20);
        check("busy settle", 1, k <= (DIV + 3) / 4 + 2);
    endtask
    task automatic txWidth(int w);
        int eff, len;
        eff = (w == 0) ? 1 : w;
        wr(PC, 32'h10 | w);
        waitIdle();
        txSerial <= 0;
        baudTick <= 1;
        @(posedge clock);
        baudTick <= 0;
        for (n = 0; txPin && n < 4; n++) @(posedge clock);
        for (len = 0; !txPin && len < 20 * DIV; len++) @(posedge clock);
        txSerial <= 1;
        check("tx width", 1, len > (eff-1)*DIV && len <= eff*DIV+1);
    endtask
    task automatic rxTry(logic [31:0] c, int len, int minLow);
        int lows;
        wr(PC, c);
        waitIdle();
        lows = 0;
        for (int k = 0; k < len + 6 * DIV; k++) begin
            rxPin <= (k >= len);
            @(posedge clock);
            lows += !rxToCore;
        end
        check("rx low", 1, minLow ? lows >= minLow : lows == 0);
    endtask

    // ======
    // Main sequence
    initial begin
        void'($urandom(32'ha904));
        repeat (6) @(posedge clock);
        reset_n <= 1;
        @(posedge clock);
        rdchk("ctrl reset", PC, 0);
        rdchk("hold reset", HD, 0);
        rdchk("busy reset", SB, 0);
        apb(1, 12'h048, 32'h1);
        check("bad addr err", 1, err);
        apb(0, 12'h000, 0);
        check("bad addr data", 0, rd);
        wr(SB, 32'hff);
        rdchk("busy ro", SB, 0);
        wr(PC, $urandom & 32'h3f);
        rdchk("ctrl back", PC, mCtrl);
        waitIdle();
        // Held writes must stay busy, then land on one tick
        wr(HD, 1);
        rdchk("hold back", HD, 1);
        base = applyCnt;
        wr(PC, 32'h25);
        extWriteStrobe <= 7'h7f;
        @(posedge clock);
        extWriteStrobe <= 0;
        repeat (3 * DIV) @(posedge clock);
        rdchk("busy held", SB, 32'hff);
        check("no apply held", base, applyCnt);
        wr(HD, 0);
        for (n = 0; extApply === 0 && n < 3 * DIV; n++) @(posedge clock);
        check("apply together", 7'h7f, extApply);
        waitIdle();
        for (int i = 0; i < 7; i++) begin
            base = applyCnt;
            extWriteStrobe <= 7'h1 << i;
            @(posedge clock);
            extWriteStrobe <= 0;
            waitIdle();
            check("apply one", base + 1, applyCnt);
        end
        // Generator off: pin follows the core one clock later
        wr(PC, 0);
        waitIdle();
        txSerial <= 0;
        repeat (2) @(posedge clock);
        check("tx follow", 0, txPin);
        txSerial <= 1;
        repeat (2) @(posedge clock);
        widths = '{0, 1, 5, 15};
        widths.push_back($urandom_range(15, 2));
        foreach (widths[i]) txWidth(widths[i]);
        rxTry(32'h00, 5, 3);
        rxTry(32'h10, 2 * DIV, 2 * DIV);
        rxTry(32'h30, DIV, 0);
        rxTry(32'h30, 3 * DIV, 2 * DIV);
        conclude();
    end
    // Cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
